//--- core/data_mem_unit.sv
// Special purpose data memory: indirect ports, bank select, jump byte, flags
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01: Unused or reserved special locations read back as zero.
// RULE_02: Indirect port accesses go to the location held in its pointer.
// RULE_03: Pointer aimed at an indirect port: read zero, write ignored.
// RULE_04: Pointer zero uses bank 0; pointer one follows bank select.
// RULE_05: Small variant: pointer bit 7 unused, always reads one.
// RULE_06: Writing the low program counter byte jumps in page, one dummy cycle.
// RULE_07: Bank select bit 0 picks bank 0 or bank 1.
// RULE_08: Direct accesses always land in bank 0.
// RULE_09: Resets clear the bank bit, except watchdog reset during idle or sleep.
// RULE_10: Special function registers are the same in both banks.
// RULE_11: Software writes to flags change arithmetic flags only.
// RULE_12: Expiry flag set by watchdog timeout; cleared by power-up, dog clear, stop.
// RULE_13: Halted flag set by stop; cleared by power-up or dog clear.
// RULE_14: Signed range flag is carry into top bit xor carry out.
// RULE_15: Zero flag follows whether the result is zero. Rotates (OP_RLC, OP_RRC) leave it unchanged here.
// RULE_16: Nibble carry from low nibble add, or no high-nibble borrow.
// RULE_17: Carry from add, no borrow on subtract, and rotate through carry.
// RULE_18: Flags are never pushed automatically on calls or interrupts.
// RULE_19: Flag bits 0-3 read/write, 4-5 read-only, 6-7 read zero.
// RULE_20: Direction bit one makes the pin input, zero makes it output.
// RULE_21: Single-bit set and clear work on data memory bits.
// RULE_22: Bank select bits 7 to 1 read as zero.
// RULE_23: Arithmetic flags update in the cycle the result is written.
module data_mem_unit #(
  parameter bit SMALL_VARIANT = 1'b0,
  parameter logic [7:0] GP_BASE = dm_pkg::GP_BASE_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic bit_set,
  input wire logic bit_clr,
  input wire logic [2:0] bit_sel,
  input wire logic alu_valid,
  input wire dm_pkg::alu_op_e alu_op,
  input wire logic [7:0] alu_operand,
  output logic [7:0] mem_rdata,
  output logic rd_valid,
  input wire logic [7:0] pc_low_in,
  output logic pc_jump,
  output logic [7:0] pc_jump_target,
  output logic dummy_cycle,
  input wire logic soft_reset,
  input wire logic dog_idle_reset,
  input wire logic dog_timeout,
  input wire logic dog_clear_instruction,
  input wire logic stop_instruction,
  output logic carry_flag,
  output logic [7:0] flag_view,
  output logic bank_select_bit,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe
);
  import dm_pkg::*;

  // ==========================================================
  // State
  logic [7:0] pointer_zero_reg;
  logic [7:0] pointer_one_reg;
  logic bank_reg;
  logic c_reg, ac_reg, z_reg, ov_reg;
  logic dog_expiry_flag_reg;
  logic halted_flag_reg;
  logic [7:0] port_a_reg;
  logic [7:0] port_a_direction_reg;
  logic [7:0] rdata_reg;
  logic rd_valid_reg;
  logic pc_jump_reg;
  logic [7:0] pc_target_reg;
  logic [7:0] ram [0:511];

  // Access decode signals
  logic is_ind0, is_ind1, is_ind, self_ind;
  logic [7:0] ptr_sel, tgt_addr, rd_val, wr_val, bit_mask;
  logic tgt_bank, is_gp, wr_any, wr_ok;
  logic [8:0] ram_idx;

  // Operation results
  logic [7:0] alu_result;
  logic alu_c, alu_ac, alu_ov, alu_z, upd_c, upd_ac, upd_ov, upd_z;

  flag_calc u_flag_calc (
    .op_a(rd_val),
    .op_b(alu_operand),
    .carry_in(c_reg),
    .op(alu_op),
    .result(alu_result),
    .c_out(alu_c),
    .ac_out(alu_ac),
    .ov_out(alu_ov),
    .z_out(alu_z),
    .upd_c(upd_c),
    .upd_ac(upd_ac),
    .upd_ov(upd_ov),
    .upd_z(upd_z)
  );

  // ==========================================================
  // Address resolution
  // The pointer picks the location, bank select picks the bank for pointer one only; the port location itself is never touched.
  always_comb begin
    is_ind0 = (mem_addr == ADDR_IND_ZERO);
    is_ind1 = (mem_addr == ADDR_IND_ONE);
    is_ind = is_ind0 || is_ind1;
    ptr_sel = is_ind0 ? pointer_zero_reg : pointer_one_reg;
    // RULE_05: bit 7 ignored on small part
    if (SMALL_VARIANT) begin
      ptr_sel[7] = 1'b0;
    end
    // RULE_02: redirect through pointer
    tgt_addr = is_ind ? ptr_sel : mem_addr;
    // RULE_04: pointer one alone follows bank
    // RULE_08: direct access stays in bank 0
    tgt_bank = is_ind1 ? bank_reg : 1'b0;
    // RULE_03: self-referencing indirect access
    self_ind = is_ind && ((tgt_addr == ADDR_IND_ZERO) || (tgt_addr == ADDR_IND_ONE));
    // RULE_10: bank only applies above the special area
    is_gp = (tgt_addr >= GP_BASE);
    ram_idx = {tgt_bank, tgt_addr};
    bit_mask = 8'h01 << bit_sel;
  end

  // ==========================================================
  // Read multiplexer
  always_comb begin
    rd_val = ZERO_BYTE;
    if (self_ind) begin
      rd_val = ZERO_BYTE;
    end else if (is_gp) begin
      rd_val = ram[ram_idx];
    end else if (tgt_addr == ADDR_PTR_ZERO) begin
      // RULE_05: bit 7 reads one on small part
      rd_val = pointer_zero_reg | {SMALL_VARIANT, 7'h00};
    end else if (tgt_addr == ADDR_PTR_ONE) begin
      rd_val = pointer_one_reg | {SMALL_VARIANT, 7'h00};
    end else if (tgt_addr == ADDR_BANK_SEL) begin
      // RULE_22: upper bank bits read zero
      rd_val = {7'h00, bank_reg};
    end else if (tgt_addr == ADDR_PC_LOW) begin
      rd_val = pc_low_in;
    end else if (tgt_addr == ADDR_FLAG) begin
      // RULE_19: top two bits read zero
      rd_val = {2'b00, dog_expiry_flag_reg, halted_flag_reg, ov_reg, z_reg, ac_reg, c_reg};
    end else if (tgt_addr == ADDR_PORT_A) begin
      rd_val = (port_a_in & port_a_direction_reg) | (port_a_reg & ~port_a_direction_reg);
    end else if (tgt_addr == ADDR_PORT_A_DIR) begin
      rd_val = port_a_direction_reg;
    end else begin
      // RULE_01: unmapped special location reads zero
      rd_val = ZERO_BYTE;
    end
  end

  // ==========================================================
  // Write value: operation result, single-bit edit, or plain data
  always_comb begin
    wr_any = mem_wr || bit_set || bit_clr || alu_valid;
    wr_ok = wr_any && !self_ind;
    if (alu_valid) begin
      wr_val = alu_result;
    // RULE_21: read-modify-write of one bit
    end else if (bit_set) begin
      wr_val = rd_val | bit_mask;
    end else if (bit_clr) begin
      wr_val = rd_val & ~bit_mask;
    end else begin
      wr_val = mem_wdata;
    end
  end

  // ==========================================================
  // General purpose RAM, no reset so it maps to plain memory
  always_ff @(posedge core_clk) begin
    if (wr_ok && is_gp) begin
      ram[ram_idx] <= wr_val;
    end
  end

  // Memory pointers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pointer_zero_reg <= PTR_RESET;
      pointer_one_reg <= PTR_RESET;
    end else if (wr_ok && tgt_addr == ADDR_PTR_ZERO) begin
      pointer_zero_reg <= wr_val;
    end else if (wr_ok && tgt_addr == ADDR_PTR_ONE) begin
      pointer_one_reg <= wr_val;
    end
  end

  // Bank select; a watchdog wake from idle must resume in the same bank
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bank_reg <= 1'b0;
    // RULE_09: clear except idle watchdog reset
    end else if (soft_reset) begin
      if (!dog_idle_reset) begin
        bank_reg <= 1'b0;
      end
    // RULE_07: bit 0 picks the bank
    end else if (wr_ok && tgt_addr == ADDR_BANK_SEL) begin
      bank_reg <= wr_val[BANK_BIT];
    end
  end

  // Jump request; the core spends the following cycle as the dummy cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pc_jump_reg <= 1'b0;
      pc_target_reg <= ZERO_BYTE;
    end else begin
      // RULE_06: low byte load jumps in page
      pc_jump_reg <= wr_ok && (tgt_addr == ADDR_PC_LOW);
      if (wr_ok && tgt_addr == ADDR_PC_LOW) begin
        pc_target_reg <= wr_val;
      end
    end
  end

  // Arithmetic flags; an operation outranks a store into the flag register itself
  // RULE_18: no save path exists, software copies the flags if it needs them
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      c_reg <= ARITH_FLAG_RESET;
      ac_reg <= ARITH_FLAG_RESET;
      z_reg <= ARITH_FLAG_RESET;
      ov_reg <= ARITH_FLAG_RESET;
    end else if (alu_valid) begin
      // RULE_23: flags with the result write
      // RULE_17: carry from adder or rotate
      if (upd_c) c_reg <= alu_c;
      if (upd_ac) ac_reg <= alu_ac;
      if (upd_ov) ov_reg <= alu_ov;
      if (upd_z) z_reg <= alu_z;
    // RULE_11: store touches bits 3 to 0 only
    end else if (wr_ok && tgt_addr == ADDR_FLAG) begin
      c_reg <= wr_val[FLAG_C_BIT];
      ac_reg <= wr_val[FLAG_AC_BIT];
      z_reg <= wr_val[FLAG_Z_BIT];
      ov_reg <= wr_val[FLAG_OV_BIT];
    end
  end

  // System flags; a timeout arriving with a clear is kept (set wins)
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dog_expiry_flag_reg <= 1'b0;
      halted_flag_reg <= 1'b0;
    end else begin
      // RULE_12: expiry set and clear sources
      if (dog_timeout) begin
        dog_expiry_flag_reg <= 1'b1;
      end else if (dog_clear_instruction || stop_instruction) begin
        dog_expiry_flag_reg <= 1'b0;
      end
      // RULE_13: halted set and clear sources
      if (stop_instruction) begin
        halted_flag_reg <= 1'b1;
      end else if (dog_clear_instruction) begin
        halted_flag_reg <= 1'b0;
      end
    end
  end

  // Port A data and direction
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      port_a_reg <= PORT_RESET;
      port_a_direction_reg <= DIR_RESET;
    end else if (wr_ok && tgt_addr == ADDR_PORT_A) begin
      port_a_reg <= wr_val;
    end else if (wr_ok && tgt_addr == ADDR_PORT_A_DIR) begin
      port_a_direction_reg <= wr_val;
    end
  end

  // Read data register, one cycle after the request
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= ZERO_BYTE;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= mem_rd;
      if (mem_rd) begin
        rdata_reg <= rd_val;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign mem_rdata = rdata_reg;
  assign rd_valid = rd_valid_reg;
  assign pc_jump = pc_jump_reg;
  assign dummy_cycle = pc_jump_reg;
  assign pc_jump_target = pc_target_reg;
  assign carry_flag = c_reg;
  assign flag_view = {2'b00, dog_expiry_flag_reg, halted_flag_reg, ov_reg, z_reg, ac_reg, c_reg};
  assign bank_select_bit = bank_reg;
  assign port_a_out = port_a_reg;
  // RULE_20: direction one means input, so no drive
  assign port_a_oe = ~port_a_direction_reg;

  // ==========================================================
  // Checks
  bank_reset_clear_a: assert property ( // RULE_09
    @(posedge core_clk) disable iff (!rstn)
    soft_reset && !dog_idle_reset |=> !bank_select_bit)
    else $error("bank bit not cleared by reset");

  bank_idle_keep_a: assert property ( // RULE_09
    @(posedge core_clk) disable iff (!rstn)
    soft_reset && dog_idle_reset |=> $stable(bank_select_bit))
    else $error("bank bit changed by idle watchdog reset");

  expiry_set_a: assert property ( // RULE_12
    @(posedge core_clk) disable iff (!rstn)
    dog_timeout |=> flag_view[FLAG_TO_BIT])
    else $error("expiry flag not set by timeout");

  halted_set_a: assert property ( // RULE_13
    @(posedge core_clk) disable iff (!rstn)
    stop_instruction |=> flag_view[FLAG_PDF_BIT]
      && (!flag_view[FLAG_TO_BIT] || $past(dog_timeout)))
    else $error("stop did not set halted flag");

  flag_store_a: assert property ( // RULE_11
    @(posedge core_clk) disable iff (!rstn)
    mem_wr && !alu_valid && tgt_addr == ADDR_FLAG && !self_ind && !dog_timeout
      && !bit_set && !bit_clr && !dog_clear_instruction && !stop_instruction
    |=> $stable(flag_view[5:4]) && flag_view[3:0] == $past(mem_wdata[3:0]))
    else $error("flag store altered system flags");

  jump_target_a: assert property ( // RULE_06
    @(posedge core_clk) disable iff (!rstn)
    mem_wr && !alu_valid && !bit_set && !bit_clr && mem_addr == ADDR_PC_LOW
    |=> pc_jump && dummy_cycle && pc_jump_target == $past(mem_wdata) ##1 !pc_jump)
    else $error("low byte load did not jump");

  self_read_a: assert property ( // RULE_03
    @(posedge core_clk) disable iff (!rstn)
    mem_rd && self_ind |=> rd_valid && mem_rdata == ZERO_BYTE)
    else $error("self indirect read not zero");

  unused_read_a: assert property ( // RULE_01
    @(posedge core_clk) disable iff (!rstn)
    mem_rd && !is_ind && mem_addr == 8'h3f && GP_BASE > 8'h3f |=> mem_rdata == ZERO_BYTE)
    else $error("unused location read not zero");

  zero_flag_a: assert property ( // RULE_15
    @(posedge core_clk) disable iff (!rstn)
    alu_valid && upd_z |=> flag_view[FLAG_Z_BIT] == ($past(alu_result) == ZERO_BYTE))
    else $error("zero flag wrong");

  direction_oe_a: assert property ( // RULE_20
    @(posedge core_clk) disable iff (!rstn)
    mem_wr && !alu_valid && !bit_set && !bit_clr && mem_addr == ADDR_PORT_A_DIR
    |=> port_a_oe == ~$past(mem_wdata))
    else $error("direction bit does not steer enable");
endmodule // data_mem_unit
`default_nettype wire

//--- core/dm_pkg.sv
// Shared constants and types for the data memory and flag block
package dm_pkg;
  // ==========================================================
  // Special function register map
  localparam logic [7:0] ADDR_IND_ZERO = 8'h00;
  localparam logic [7:0] ADDR_PTR_ZERO = 8'h01;
  localparam logic [7:0] ADDR_IND_ONE = 8'h02;
  localparam logic [7:0] ADDR_PTR_ONE = 8'h03;
  localparam logic [7:0] ADDR_BANK_SEL = 8'h04;
  localparam logic [7:0] ADDR_PC_LOW = 8'h06;
  localparam logic [7:0] ADDR_FLAG = 8'h0a;
  localparam logic [7:0] ADDR_PORT_A = 8'h12;
  localparam logic [7:0] ADDR_PORT_A_DIR = 8'h13;
  localparam logic [7:0] GP_BASE_DEFAULT = 8'h40;

  // ==========================================================
  // Flag register and bank select bit positions
  localparam int FLAG_C_BIT = 0;
  localparam int FLAG_AC_BIT = 1;
  localparam int FLAG_Z_BIT = 2;
  localparam int FLAG_OV_BIT = 3;
  localparam int FLAG_PDF_BIT = 4;
  localparam int FLAG_TO_BIT = 5;
  localparam int BANK_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic ARITH_FLAG_RESET = 1'b0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ==========================================================
  // Operations that produce flags
  typedef enum logic [3:0] {
    OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR, OP_RLC, OP_RRC
  } alu_op_e;
endpackage

//--- core/flag_calc.sv
// Result and arithmetic flag generation for one operation
`timescale 1ns/1ps
`default_nettype none
module flag_calc (
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  input wire logic carry_in,
  input wire dm_pkg::alu_op_e op,
  output logic [7:0] result,
  output logic c_out,
  output logic ac_out,
  output logic ov_out,
  output logic z_out,
  output logic upd_c,
  output logic upd_ac,
  output logic upd_ov,
  output logic upd_z
);
  import dm_pkg::*;

  logic [7:0] b_eff;
  logic cin_eff;
  logic [8:0] sum9;
  logic [4:0] low5;
  logic carry7;
  logic is_arith;

  // ==========================================================
  // Adder shared by add and subtract; subtract is a + ~b + 1
  always_comb begin
    is_arith = (op == OP_ADD) || (op == OP_ADC) || (op == OP_SUB) || (op == OP_SBC);
    b_eff = ((op == OP_SUB) || (op == OP_SBC)) ? ~op_b : op_b;
    cin_eff = (op == OP_SUB) ? 1'b1 : (((op == OP_ADC) || (op == OP_SBC)) ? carry_in : 1'b0);
    sum9 = {1'b0, op_a} + {1'b0, b_eff} + {8'h00, cin_eff};
    low5 = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
    carry7 = op_a[7] ^ b_eff[7] ^ sum9[7];
  end

  // ==========================================================
  // Result selection and flag values
  always_comb begin
    result = sum9[7:0];
    c_out = sum9[8];
    upd_c = is_arith;
    upd_ac = is_arith;
    upd_ov = is_arith;
    upd_z = 1'b1;
    case (op)
      OP_AND: result = op_a & op_b;
      OP_OR: result = op_a | op_b;
      OP_XOR: result = op_a ^ op_b;
      OP_RLC: begin
        result = {op_a[6:0], carry_in};
        c_out = op_a[7];
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      OP_RRC: begin
        result = {carry_in, op_a[7:1]};
        c_out = op_a[0];
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      default: result = sum9[7:0];
    endcase
    // RULE_16: nibble carry out
    ac_out = low5[4];
    // RULE_14: carry in versus out
    ov_out = carry7 ^ sum9[8];
    // RULE_15: zero result
    z_out = (result == ZERO_BYTE);
  end
endmodule // flag_calc
`default_nettype wire

//--- verif/core_pc_model.sv
// Core side model: follows program counter low byte jumps
`timescale 1ns/1ps
`default_nettype none
module core_pc_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic pc_jump,
  input wire logic [7:0] pc_jump_target,
  output logic [7:0] pc_low_in
);
  // ====
  // Program counter low byte
  // Holds still between jumps so a read back shows only the jump effect
  // load jump target in page
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pc_low_in <= 8'h00;
    end else if (pc_jump) begin
      pc_low_in <= pc_jump_target;
    end
  end
endmodule // core_pc_model
`default_nettype wire

//--- verif/data_memory_indirect_and_flags_tb.sv
// Self-checking bench for the data memory and flag unit
`timescale 1ns/1ps
`default_nettype none
module data_memory_indirect_and_flags_tb;
  import dm_pkg::*;
  logic core_clk, rstn, mem_rd, mem_wr, bit_set, bit_clr, alu_valid;
  logic [7:0] mem_addr, mem_wdata, alu_operand, mem_rdata, pc_low_in, pc_jump_target;
  logic [7:0] flag_view, port_a_in, port_a_out, port_a_oe;
  logic [2:0] bit_sel;
  alu_op_e alu_op;
  logic rd_valid, pc_jump, dummy_cycle, carry_flag, bank_select_bit;
  logic soft_reset, dog_idle_reset, dog_timeout, dog_clear_instruction, stop_instruction;
  logic [4:0] ev;
  int failures = 0;
  int n_tests = 0;
  // Event pulses travel as one vector so a task can raise any mix
  assign {soft_reset, dog_idle_reset, dog_timeout, dog_clear_instruction, stop_instruction} = ev;

  data_mem_unit dut (
    .core_clk(core_clk), .rstn(rstn), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .bit_set(bit_set), .bit_clr(bit_clr),
    .bit_sel(bit_sel), .alu_valid(alu_valid), .alu_op(alu_op), .alu_operand(alu_operand),
    .mem_rdata(mem_rdata), .rd_valid(rd_valid), .pc_low_in(pc_low_in),
    .pc_jump(pc_jump), .pc_jump_target(pc_jump_target), .dummy_cycle(dummy_cycle),
    .soft_reset(soft_reset), .dog_idle_reset(dog_idle_reset), .dog_timeout(dog_timeout),
    .dog_clear_instruction(dog_clear_instruction), .stop_instruction(stop_instruction),
    .carry_flag(carry_flag), .flag_view(flag_view), .bank_select_bit(bank_select_bit),
    .port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe(port_a_oe)
  );
  core_pc_model core (
    .core_clk(core_clk), .rstn(rstn), .pc_jump(pc_jump),
    .pc_jump_target(pc_jump_target), .pc_low_in(pc_low_in)
  );
  // Small variant fed the same stimulus; only its read data is judged
  logic [7:0] small_rdata;
  data_mem_unit #(.SMALL_VARIANT(1'b1)) dut_small (
    .core_clk(core_clk), .rstn(rstn), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .bit_set(bit_set), .bit_clr(bit_clr),
    .bit_sel(bit_sel), .alu_valid(alu_valid), .alu_op(alu_op), .alu_operand(alu_operand),
    .mem_rdata(small_rdata), .rd_valid(), .pc_low_in(pc_low_in),
    .pc_jump(), .pc_jump_target(), .dummy_cycle(),
    .soft_reset(soft_reset), .dog_idle_reset(dog_idle_reset), .dog_timeout(dog_timeout),
    .dog_clear_instruction(dog_clear_instruction), .stop_instruction(stop_instruction),
    .carry_flag(), .flag_view(), .bank_select_bit(),
    .port_a_in(port_a_in), .port_a_out(), .port_a_oe()
  );

  // ====
  // Clock, 40 ns period
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ====
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Requests rise and fall on falling edges; the rising edge between takes them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(negedge core_clk);
    mem_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    mem_addr = a;
    mem_rd = 1'b1;
    @(negedge core_clk);
    mem_rd = 1'b0;
    chk({7'h00, rd_valid}, 8'h01);
    chk(mem_rdata, exp);
  endtask
  task automatic alu(input alu_op_e op, input logic [7:0] a, input logic [7:0] b);
    @(negedge core_clk);
    mem_addr = a;
    alu_op = op;
    alu_operand = b;
    alu_valid = 1'b1;
    @(negedge core_clk);
    alu_valid = 1'b0;
  endtask
  task automatic pulse(input logic [4:0] v);
    @(negedge core_clk);
    ev = v;
    @(negedge core_clk);
    ev = 5'h00;
  endtask
  task automatic bitop(input logic s, input logic c, input logic [7:0] a, input logic [2:0] k);
    @(negedge core_clk);
    mem_addr = a;
    bit_sel = k;
    bit_set = s;
    bit_clr = c;
    @(negedge core_clk);
    bit_set = 1'b0;
    bit_clr = 1'b0;
  endtask
  // Flags seen on the edge after the operation, then the stored result
  task automatic alu_case(input alu_op_e op, input logic [7:0] pre, a, b, res, fl);
    wr(ADDR_FLAG, pre);
    wr(8'h42, a);
    alu(op, 8'h42, b);
    chk({4'h0, flag_view[3:0]}, fl);
    chk({7'h00, carry_flag}, {7'h00, fl[0]});
    rd(8'h42, res);
  endtask

  // ====
  // Scenarios
  task automatic t_reset();
    chk(flag_view, 8'h00);
    chk(port_a_oe, 8'h00);
    rd(ADDR_BANK_SEL, 8'h00);
    rd(ADDR_PORT_A_DIR, DIR_RESET);
  endtask
  task automatic t_unused();
    wr(8'h05, 8'h5a);
    rd(8'h05, 8'h00);
    rd(8'h3f, 8'h00);
  endtask
  task automatic t_indirect();
    wr(8'h40, 8'h5a);
    wr(ADDR_PTR_ZERO, 8'h40);
    rd(ADDR_IND_ZERO, 8'h5a);
    wr(ADDR_IND_ZERO, 8'ha5);
    rd(8'h40, 8'ha5);
    rd(ADDR_PTR_ZERO, 8'h40);
    wr(ADDR_PTR_ZERO, ADDR_IND_ONE);
    wr(ADDR_IND_ZERO, 8'h33);
    rd(ADDR_IND_ZERO, 8'h00);
  endtask
  task automatic t_bank();
    wr(8'h41, 8'h11);
    wr(ADDR_BANK_SEL, 8'hff);
    rd(ADDR_BANK_SEL, 8'h01);
    chk({7'h00, bank_select_bit}, 8'h01);
    wr(ADDR_PTR_ONE, 8'h41);
    wr(ADDR_IND_ONE, 8'h77);
    rd(8'h41, 8'h11);
    rd(ADDR_IND_ONE, 8'h77);
    wr(ADDR_PTR_ZERO, 8'h41);
    rd(ADDR_IND_ZERO, 8'h11);
    wr(ADDR_PTR_ONE, ADDR_BANK_SEL);
    rd(ADDR_IND_ONE, 8'h01);
    pulse(5'b11000);
    chk({7'h00, bank_select_bit}, 8'h01);
    pulse(5'b10000);
    chk({7'h00, bank_select_bit}, 8'h00);
  endtask
  task automatic t_jump();
    wr(ADDR_PC_LOW, 8'h3c);
    chk({6'h00, pc_jump, dummy_cycle}, 8'h03);
    chk(pc_jump_target, 8'h3c);
    @(negedge core_clk);
    chk({7'h00, pc_jump}, 8'h00);
    rd(ADDR_PC_LOW, 8'h3c);
  endtask
  task automatic t_alu();
    alu_case(OP_ADD, 8'h00, 8'h7f, 8'h01, 8'h80, 8'h0a);
    alu_case(OP_ADD, 8'h00, 8'hff, 8'h01, 8'h00, 8'h07);
    alu_case(OP_ADC, 8'h01, 8'h01, 8'h01, 8'h03, 8'h00);
    alu_case(OP_SUB, 8'h00, 8'h10, 8'h01, 8'h0f, 8'h01);
    alu_case(OP_SUB, 8'h00, 8'h80, 8'h01, 8'h7f, 8'h09);
    alu_case(OP_SBC, 8'h00, 8'h05, 8'h04, 8'h00, 8'h07);
    alu_case(OP_AND, 8'h04, 8'hff, 8'h01, 8'h01, 8'h00);
    alu_case(OP_OR, 8'h0f, 8'h00, 8'h10, 8'h10, 8'h0b);
    alu_case(OP_XOR, 8'h00, 8'h5a, 8'h5a, 8'h00, 8'h04);
    alu_case(OP_RLC, 8'h00, 8'h81, 8'h00, 8'h02, 8'h01);
    alu_case(OP_RRC, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01);
  endtask
  task automatic t_flags();
    wr(ADDR_FLAG, 8'h00);
    pulse(5'b00100);
    chk(flag_view, 8'h20);
    pulse(5'b00001);
    chk(flag_view, 8'h10);
    wr(ADDR_FLAG, 8'hff);
    rd(ADDR_FLAG, 8'h1f);
    wr(ADDR_FLAG, 8'h00);
    pulse(5'b00100);
    pulse(5'b10000);
    chk(flag_view, 8'h30);
    pulse(5'b00010);
    chk(flag_view, 8'h00);
  endtask
  task automatic t_bits();
    wr(8'h43, 8'h00);
    bitop(1'b1, 1'b0, 8'h43, 3'd5);
    rd(8'h43, 8'h20);
    bitop(1'b0, 1'b1, 8'h43, 3'd5);
    rd(8'h43, 8'h00);
    bitop(1'b0, 1'b1, ADDR_PORT_A_DIR, 3'd0);
    chk(port_a_oe, 8'h01);
    wr(ADDR_PORT_A, 8'h5a);
    chk(port_a_out, 8'h5a);
    wr(ADDR_PORT_A_DIR, 8'h0f);
    chk(port_a_oe, 8'hf0);
    rd(ADDR_PORT_A, 8'h5c);
  endtask
  // Small variant: pointer top bit reads one and does not steer the address
  task automatic t_small();
    wr(ADDR_PTR_ZERO, 8'h40);
    rd(ADDR_PTR_ZERO, 8'h40);
    chk(small_rdata, 8'hc0);
    wr(8'hc0, 8'h66);
    wr(ADDR_PTR_ZERO, 8'hc0);
    rd(ADDR_IND_ZERO, 8'h66);
    chk(small_rdata, 8'ha5);
  endtask

  // ====
  // Main sequence and hang guard
  initial begin
    rstn = 1'b0;
    {mem_rd, mem_wr, bit_set, bit_clr, alu_valid} = 5'h00;
    mem_addr = 8'h00;
    mem_wdata = 8'h00;
    alu_operand = 8'h00;
    alu_op = OP_ADD;
    bit_sel = 3'd0;
    port_a_in = 8'h3c;
    ev = 5'h00;
    repeat (10) @(negedge core_clk);
    rstn = 1'b1;
    t_reset();
    t_unused();
    t_indirect();
    t_bank();
    t_jump();
    t_alu();
    t_flags();
    t_bits();
    t_small();
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    end_sim();
  end
endmodule // data_memory_indirect_and_flags_tb
`default_nettype wire
